//--- pkg/sphc_defs.svh
`ifndef SPHC_DEFS_SVH
`define SPHC_DEFS_SVH
// Contract
// [RL1] Balanced control hysteresis puts half the band above, half below.
// [RL2] Alarm hysteresis lies wholly on the inactive side of the level.
// [RL3] Control setpoints never latch; only alarm setpoints may latch.
// [RL4] Alarms act at once unless delayed; release after hysteresis retreat.
// [RL5] First direction bit: 0 active above level, 1 active below.
// [RL6] First polarity bit: 0 transistor on while active, 1 off.
// [RL7] First source bit: 0 compares net value, 1 gross value.
// [RL8] Second direction bit: 0 active above level, 1 active below.
// [RL9] Second polarity bit: 0 transistor on while active, 1 off.
// [RL10] Second source bit: 0 compares net value, 1 gross value.
// [RL11] Control group disable: 0 enables both control setpoints, 1 disables.
// [RL12] Deadband style: 0 both sides of level, 1 one side only.
// [RL13] Comparisons use unfiltered or filtered measurements as configured.
// [RL14] Alarm action waits a configurable number of readings.
// [RL15] Four setpoint outputs, each with its own indicator.
// [RL16] Alarms run independent or ganged to a control setpoint, incl. band.
// [RL17] Active above, below, outside band and inside band detection.
// [RL18] Per-setpoint lock bit 1 refuses edits to that level.
// [RL19] A latched alarm holds until panel, external or serial reset.
// [RL20] Comparisons and state updates occur once per completed reading.

// ==========================================================================
// Field encodings
`define SPHC_DIR_ABOVE 1'b0
`define SPHC_DIR_BELOW 1'b1
`define SPHC_SRC_GROSS 1'b1
`define SPHC_STYLE_BALANCED 1'b0
`define SPHC_GROUP_DISABLED 1'b1
`define SPHC_LOCKED 1'b1

// ==========================================================================
// Widths and reset values
`define SPHC_LEVEL_W 24
`define SPHC_DELAY_W 8
`define SPHC_NUM_SP 4
`define SPHC_NUM_CTRL 2
`define SPHC_LEVEL_RST 24'h00_0000
`define SPHC_ACT_RST 1'b0

`endif

//--- pkg/sphc_pkg.sv
`include "sphc_defs.svh"
package sphc_pkg;
  // Placement of an alarm level relative to its control setpoint.
  typedef enum logic [1:0] {
    SPHC_GANG_INDEP,
    SPHC_GANG_ABOVE,
    SPHC_GANG_BELOW,
    SPHC_GANG_BAND
  } sphc_gang_type;
endpackage

//--- hdl/sphc_setpoint_comparator.sv
`timescale 1ns/1ps
`include "sphc_defs.svh"
module sphc_setpoint_comparator #(
  parameter int W = `SPHC_LEVEL_W,
  parameter int DW = `SPHC_DELAY_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic meas_valid,
  input wire logic use_filtered,
  input wire logic signed [W-1:0] net_raw,
  input wire logic signed [W-1:0] net_filt,
  input wire logic signed [W-1:0] gross_raw,
  input wire logic signed [W-1:0] gross_filt,
  input wire logic first_direction_bit,
  input wire logic first_output_polarity,
  input wire logic first_source_select,
  input wire logic second_direction_bit,
  input wire logic second_output_polarity,
  input wire logic second_source_select,
  input wire logic control_group_disable,
  input wire logic deadband_style_select,
  input wire logic [W-1:0] control_hysteresis,
  input wire logic alarm_a_direction_bit,
  input wire logic alarm_a_output_polarity,
  input wire logic alarm_a_source_select,
  input wire logic alarm_b_direction_bit,
  input wire logic alarm_b_output_polarity,
  input wire logic alarm_b_source_select,
  input wire logic alarm_group_disable,
  input wire logic ext_reset_enable,
  input wire sphc_pkg::sphc_gang_type alarm_a_gang,
  input wire sphc_pkg::sphc_gang_type alarm_b_gang,
  input wire logic alarm_a_latch,
  input wire logic alarm_b_latch,
  input wire logic [DW-1:0] alarm_a_delay,
  input wire logic [DW-1:0] alarm_b_delay,
  input wire logic [W-1:0] alarm_a_hysteresis,
  input wire logic [W-1:0] alarm_b_hysteresis,
  input wire logic panel_reset,
  input wire logic ext_reset_req,
  input wire logic serial_reset,
  input wire logic level_wr_en,
  input wire logic [1:0] level_wr_sel,
  input wire logic signed [W-1:0] level_wr_data,
  input wire logic first_level_lock,
  input wire logic second_level_lock,
  input wire logic third_level_lock,
  input wire logic fourth_level_lock,
  output logic [`SPHC_NUM_SP-1:0] sp_out_r,
  output logic [`SPHC_NUM_SP-1:0] led_r,
  output logic level_wr_refused_r
);
  import sphc_pkg::*;

  localparam int NSP = `SPHC_NUM_SP;
  localparam int NCT = `SPHC_NUM_CTRL;
  localparam int XW = W + 2;

  // ==========================================================================
  // Per-setpoint configuration gathered into arrays
  logic signed [W-1:0] level_r [NSP];
  logic act_r [NSP];
  logic [DW-1:0] dly_cnt_r [NSP];
  logic dir [NSP];
  logic pol [NSP];
  logic src [NSP];
  logic dis [NSP];
  logic latch [NSP];
  logic lock [NSP];
  logic [DW-1:0] dly [NSP];
  logic [W-1:0] hyst [NSP];
  sphc_gang_type gang [NSP];
  logic signed [W-1:0] base [NSP];
  logic on_cond [NSP];
  logic off_cond [NSP];
  logic act_nxt [NSP];
  logic signed [W-1:0] net_sel;
  logic signed [W-1:0] gross_sel;
  logic rst_evt;

  assign net_sel = use_filtered ? net_filt : net_raw; // see [RL13]
  assign gross_sel = use_filtered ? gross_filt : gross_raw; // see [RL13]
  // External reset counts only while it is enabled.
  assign rst_evt = panel_reset | serial_reset
                   | (ext_reset_enable & ext_reset_req); // see [RL19]

  always_comb begin
    dir[0] = first_direction_bit; // see [RL5]
    dir[1] = second_direction_bit; // see [RL8]
    dir[2] = alarm_a_direction_bit;
    dir[3] = alarm_b_direction_bit;
    pol[0] = first_output_polarity;
    pol[1] = second_output_polarity;
    pol[2] = alarm_a_output_polarity;
    pol[3] = alarm_b_output_polarity;
    src[0] = first_source_select; // see [RL7]
    src[1] = second_source_select; // see [RL10]
    src[2] = alarm_a_source_select;
    src[3] = alarm_b_source_select;
    dis[0] = control_group_disable == `SPHC_GROUP_DISABLED; // see [RL11]
    dis[1] = control_group_disable == `SPHC_GROUP_DISABLED; // see [RL11]
    dis[2] = alarm_group_disable == `SPHC_GROUP_DISABLED;
    dis[3] = alarm_group_disable == `SPHC_GROUP_DISABLED;
    latch[0] = 1'b0; // see [RL3]
    latch[1] = 1'b0; // see [RL3]
    latch[2] = alarm_a_latch;
    latch[3] = alarm_b_latch;
    dly[0] = '0;
    dly[1] = '0;
    dly[2] = alarm_a_delay;
    dly[3] = alarm_b_delay;
    hyst[0] = control_hysteresis;
    hyst[1] = control_hysteresis;
    hyst[2] = alarm_a_hysteresis;
    hyst[3] = alarm_b_hysteresis;
    gang[0] = SPHC_GANG_INDEP;
    gang[1] = SPHC_GANG_INDEP;
    gang[2] = alarm_a_gang;
    gang[3] = alarm_b_gang;
    base[0] = '0;
    base[1] = '0;
    base[2] = level_r[0];
    base[3] = level_r[1];
    lock[0] = first_level_lock;
    lock[1] = second_level_lock;
    lock[2] = third_level_lock;
    lock[3] = fourth_level_lock;
  end

  // ==========================================================================
  // Level edits
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < NSP; k++) begin
        level_r[k] <= `SPHC_LEVEL_RST;
      end
    end else if (level_wr_en && lock[level_wr_sel] != `SPHC_LOCKED) begin
      level_r[level_wr_sel] <= level_wr_data; // see [RL18]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_wr_refused_r <= 1'b0;
    end else begin
      level_wr_refused_r <= level_wr_en
        && lock[level_wr_sel] == `SPHC_LOCKED; // see [RL18]
    end
  end

  // ==========================================================================
  // Threshold evaluation and state per setpoint
  // Sums run two bits wider than the levels so that guard bands never wrap.
  for (genvar i = 0; i < NSP; i++) begin : g_sp
    logic signed [XW-1:0] v;
    logic signed [XW-1:0] lv;
    logic signed [XW-1:0] amt;
    logic signed [XW-1:0] hy;
    logic signed [XW-1:0] half;
    logic bal;

    always_comb begin
      v = src[i] == `SPHC_SRC_GROSS ? XW'(gross_sel) : XW'(net_sel);
      amt = XW'(level_r[i]);
      hy = $signed({2'b00, hyst[i]});
      bal = (i < NCT) && deadband_style_select == `SPHC_STYLE_BALANCED;
      half = bal ? (hy >>> 1) : '0; // see [RL1] [RL12]
      unique case (gang[i]) // see [RL16]
        SPHC_GANG_ABOVE: lv = XW'(base[i]) + amt;
        SPHC_GANG_BELOW: lv = XW'(base[i]) - amt;
        SPHC_GANG_BAND: lv = XW'(base[i]);
        SPHC_GANG_INDEP: lv = amt;
      endcase
      if (gang[i] == SPHC_GANG_BAND) begin
        if (dir[i] == `SPHC_DIR_ABOVE) begin
          // Active outside the band, hysteresis inside it.
          on_cond[i] = v > lv + amt || v < lv - amt; // see [RL17]
          off_cond[i] = v <= lv + amt - hy && v >= lv - amt + hy; // see [RL2]
        end else begin
          on_cond[i] = v < lv + amt && v > lv - amt; // see [RL17]
          off_cond[i] = v > lv + amt + hy || v < lv - amt - hy; // see [RL2]
        end
      end else if (bal) begin
        if (dir[i] == `SPHC_DIR_ABOVE) begin
          on_cond[i] = v > lv + half; // see [RL1]
          off_cond[i] = v < lv - half; // see [RL1]
        end else begin
          on_cond[i] = v < lv - half; // see [RL1]
          off_cond[i] = v > lv + half; // see [RL1]
        end
      end else begin
        if (dir[i] == `SPHC_DIR_ABOVE) begin
          on_cond[i] = v > lv; // see [RL17]
          off_cond[i] = v < lv - hy; // see [RL2] [RL12]
        end else begin
          on_cond[i] = v < lv; // see [RL17]
          off_cond[i] = v > lv + hy; // see [RL2] [RL12]
        end
      end
    end

    // A set on a reading wins over a reset event arriving in the same cycle.
    always_comb begin
      act_nxt[i] = act_r[i];
      if (dis[i]) begin
        act_nxt[i] = 1'b0; // see [RL11]
      end else if (meas_valid && on_cond[i] && dly_cnt_r[i] >= dly[i]) begin
        act_nxt[i] = 1'b1; // see [RL4] [RL20]
      end else if ((meas_valid && off_cond[i] && !latch[i])
                   || (latch[i] && rst_evt)) begin
        act_nxt[i] = 1'b0; // see [RL4] [RL19]
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        act_r[i] <= `SPHC_ACT_RST;
      end else begin
        act_r[i] <= act_nxt[i];
      end
    end

    // Counts consecutive out-of-limit readings; saturates at the delay.
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        dly_cnt_r[i] <= '0;
      end else if (dis[i]) begin
        dly_cnt_r[i] <= '0;
      end else if (meas_valid) begin
        if (!on_cond[i]) begin
          dly_cnt_r[i] <= '0;
        end else if (dly_cnt_r[i] < dly[i]) begin
          dly_cnt_r[i] <= dly_cnt_r[i] + 1'b1; // see [RL14]
        end
      end
    end
  end

  // ==========================================================================
  // Output transistors and indicators
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_out_r <= '0;
      led_r <= '0;
    end else begin
      for (int k = 0; k < NSP; k++) begin
        sp_out_r[k] <= act_nxt[k] ^ pol[k]; // see [RL6] [RL9] [RL15]
        led_r[k] <= act_nxt[k]; // see [RL15]
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic signed [XW-1:0] chk_v0;
  logic signed [XW-1:0] chk_l0;
  logic signed [XW-1:0] chk_h0;
  assign chk_v0 = first_source_select ? XW'(gross_sel) : XW'(net_sel);
  assign chk_l0 = XW'(level_r[0]);
  assign chk_h0 = $signed({2'b00, control_hysteresis}) >>> 1;

  property p_pol0;
    sp_out_r[0] == (act_r[0] ^ $past(first_output_polarity));
  endproperty
  a_pol0: assert property (p_pol0) // see [RL6]
    else $error("Control level a drive polarity wrong");

  property p_pol1;
    led_r[1] |-> sp_out_r[1] != $past(second_output_polarity);
  endproperty
  a_pol1: assert property (p_pol1) // see [RL9]
    else $error("Control level b drive polarity wrong");

  property p_ctrl_on_reading;
    !meas_valid && !control_group_disable |=> $stable(led_r[1:0]);
  endproperty
  a_ctrl_on_reading: assert property (p_ctrl_on_reading) // see [RL20]
    else $error("Control state changed without a reading");

  // A disabled setpoint shows its inactive drive, whatever the polarity.
  property p_group_disable;
    control_group_disable |=> led_r[1:0] == 2'b00
      && sp_out_r[1:0] == $past({second_output_polarity,
                                 first_output_polarity});
  endproperty
  a_group_disable: assert property (p_group_disable) // see [RL11]
    else $error("Disabled control setpoint active");

  property p_balanced_on;
    meas_valid && !control_group_disable && !deadband_style_select
      && !first_direction_bit && chk_v0 > chk_l0 + chk_h0 |=> led_r[0];
  endproperty
  a_balanced_on: assert property (p_balanced_on) // see [RL1]
    else $error("Control level a not active above upper half band");

  property p_balanced_hold;
    meas_valid && !control_group_disable && !deadband_style_select
      && !first_direction_bit && act_r[0] && chk_v0 >= chk_l0 - chk_h0
      |=> led_r[0];
  endproperty
  a_balanced_hold: assert property (p_balanced_hold) // see [RL1]
    else $error("Control level a released inside lower half band");

  property p_lock;
    level_wr_en && lock[level_wr_sel] |=> level_wr_refused_r
      && level_r[$past(level_wr_sel)] == $past(level_r[level_wr_sel]);
  endproperty
  a_lock: assert property (p_lock) // see [RL18]
    else $error("Locked level was edited");

  property p_alarm_immediate;
    meas_valid && !alarm_group_disable && alarm_a_delay == '0
      && on_cond[2] |=> led_r[2];
  endproperty
  a_alarm_immediate: assert property (p_alarm_immediate) // see [RL4]
    else $error("Undelayed alarm did not act at once");

  property p_alarm_delay;
    meas_valid && !alarm_group_disable && !act_r[2]
      && dly_cnt_r[2] < alarm_a_delay |=> !led_r[2];
  endproperty
  a_alarm_delay: assert property (p_alarm_delay) // see [RL14]
    else $error("Alarm acted before its delay");

  property p_latch_hold;
    alarm_a_latch && act_r[2] && !alarm_group_disable && !rst_evt
      |=> led_r[2];
  endproperty
  a_latch_hold: assert property (p_latch_hold) // see [RL19]
    else $error("Latched alarm dropped without reset");

  property p_latch_clear;
    alarm_a_latch && rst_evt && !alarm_group_disable
      && !(meas_valid && on_cond[2]) |=> !led_r[2];
  endproperty
  a_latch_clear: assert property (p_latch_clear) // see [RL19]
    else $error("Reset event did not clear latched alarm");

  c_latched: cover property (alarm_a_latch && act_r[2] ##3 rst_evt);
  c_refused: cover property (level_wr_en && lock[level_wr_sel]);
  c_ctrl_cycle: cover property (led_r[0] ##[1:50] !led_r[0]);
  c_band: cover property (alarm_b_gang == SPHC_GANG_BAND && led_r[3]);
endmodule

//--- tb/sphc_load_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Pulled-up loads on the open-collector setpoint outputs
module sphc_load_model (
  input wire logic [3:0] sp_out_r,
  output logic [3:0] pin_level
);
  // A conducting transistor sinks its load; an off one lets the pull-up win.
  assign pin_level = ~sp_out_r;
endmodule

//--- tb/sphc_setpoint_comparator_bench.sv
`timescale 1ns/1ps
module sphc_setpoint_comparator_bench;
  import sphc_pkg::*;
  logic sys_clk, rst_n, meas_valid, use_filtered, level_wr_en;
  logic signed [23:0] net_raw, net_filt, gross_raw, gross_filt;
  logic signed [23:0] level_wr_data;
  logic first_direction_bit, first_output_polarity, first_source_select;
  logic second_direction_bit, second_output_polarity, second_source_select;
  logic alarm_a_direction_bit, alarm_a_output_polarity, alarm_a_source_select;
  logic alarm_b_direction_bit, alarm_b_output_polarity, alarm_b_source_select;
  logic control_group_disable, deadband_style_select, alarm_group_disable;
  logic ext_reset_enable, alarm_a_latch, alarm_b_latch;
  logic panel_reset, ext_reset_req, serial_reset;
  logic first_level_lock, second_level_lock, third_level_lock;
  logic fourth_level_lock, level_wr_refused_r;
  logic [23:0] control_hysteresis, alarm_a_hysteresis, alarm_b_hysteresis;
  logic [7:0] alarm_a_delay, alarm_b_delay;
  logic [1:0] level_wr_sel;
  logic [3:0] sp_out_r, led_r, pin_level;
  sphc_gang_type alarm_a_gang, alarm_b_gang;
  int err_count, check_count;

  sphc_setpoint_comparator i_dut (
    .sys_clk, .rst_n, .meas_valid, .use_filtered, .net_raw, .net_filt,
    .gross_raw, .gross_filt, .first_direction_bit, .first_output_polarity,
    .first_source_select, .second_direction_bit, .second_output_polarity,
    .second_source_select, .control_group_disable, .deadband_style_select,
    .control_hysteresis, .alarm_a_direction_bit, .alarm_a_output_polarity,
    .alarm_a_source_select, .alarm_b_direction_bit, .alarm_b_output_polarity,
    .alarm_b_source_select, .alarm_group_disable, .ext_reset_enable,
    .alarm_a_gang, .alarm_b_gang, .alarm_a_latch, .alarm_b_latch,
    .alarm_a_delay, .alarm_b_delay, .alarm_a_hysteresis, .alarm_b_hysteresis,
    .panel_reset, .ext_reset_req, .serial_reset, .level_wr_en, .level_wr_sel,
    .level_wr_data, .first_level_lock, .second_level_lock, .third_level_lock,
    .fourth_level_lock, .sp_out_r, .led_r, .level_wr_refused_r
  );

  sphc_load_model i_load (.sp_out_r, .pin_level);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ========================================================================
  // Shared checking and bus tasks
  task automatic chk(string nm, logic [23:0] seen, logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("Checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // The filtered inputs sit 1000 above the raw ones so a wrong pick shows.
  task automatic rd(int n, int g, logic [3:0] e);
    logic [3:0] pol;
    logic [3:0] pin_e;
    pol = {alarm_b_output_polarity, alarm_a_output_polarity,
      second_output_polarity, first_output_polarity};
    pin_e = ~(e ^ pol);
    net_raw = 24'(n);
    gross_raw = 24'(g);
    net_filt = 24'(n + 1000);
    gross_filt = 24'(g + 1000);
    meas_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    meas_valid = 1'b0;
    chk("led", led_r, e);
    chk("out", sp_out_r, e ^ pol);
    chk("pin", pin_level, pin_e);
    @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(logic [1:0] s, int d, logic rf);
    level_wr_sel = s;
    level_wr_data = 24'(d);
    level_wr_en = 1'b1;
    @(posedge sys_clk);
    #1;
    level_wr_en = 1'b0;
    chk("refused", level_wr_refused_r, rf);
    @(posedge sys_clk);
    #1;
  endtask

  // ========================================================================
  // Scenarios
  task automatic t_ctrl;
    chk("out_rst", sp_out_r, 4'ha);
    control_hysteresis = 24'h00_000a;
    wr(0, 100, 1'b0);
    wr(1, 1000, 1'b0);
    rd(101, 0, 4'h1);
    rd(95, 0, 4'h1);
    rd(89, 0, 4'h0);
    deadband_style_select = 1'b0;
    rd(104, 0, 4'h0);
    rd(106, 0, 4'h1);
    rd(96, 0, 4'h1);
    rd(94, 0, 4'h0);
    for (int i = 0; i < 4; i++) begin
      {fourth_level_lock, third_level_lock, second_level_lock,
        first_level_lock} = 4'(1 << i);
      wr(2'(i), 5000, 1'b1);
    end
    {fourth_level_lock, third_level_lock, second_level_lock,
      first_level_lock} = 4'h0;
    rd(106, 0, 4'h1);
    rd(94, 0, 4'h0);
  endtask

  task automatic t_dir;
    deadband_style_select = 1'b1;
    first_direction_bit = 1'b1;
    second_direction_bit = 1'b1;
    second_source_select = 1'b1;
    rd(50, 2000, 4'h1);
    rd(105, 1005, 4'h1);
    rd(111, 999, 4'h2);
    first_source_select = 1'b1;
    rd(50, 500, 4'h2);
    first_output_polarity = 1'b1;
    second_output_polarity = 1'b0;
    rd(50, 500, 4'h2);
    control_group_disable = 1'b1;
    rd(50, 500, 4'h0);
    control_group_disable = 1'b0;
    rd(50, 500, 4'h2);
  endtask

  task automatic t_filt;
    {first_direction_bit, first_source_select} = 2'h0;
    {second_direction_bit, second_source_select} = 2'h0;
    use_filtered = 1'b1;
    rd(50, 0, 4'h3);
    use_filtered = 1'b0;
    rd(50, 0, 4'h0);
  endtask

  task automatic t_alarm;
    control_group_disable = 1'b1;
    alarm_group_disable = 1'b0;
    alarm_a_hysteresis = 24'h00_0014;
    alarm_a_delay = 8'h02;
    {alarm_b_direction_bit, alarm_b_source_select} = 2'h3;
    wr(2, 200, 1'b0);
    wr(3, -100, 1'b0);
    rd(201, 0, 4'h0);
    rd(201, 0, 4'h0);
    rd(201, 0, 4'h4);
    rd(185, 0, 4'h4);
    rd(179, 0, 4'h0);
    alarm_a_delay = 8'h00;
    alarm_a_latch = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(201, 0, 4'h4);
      rd(150, 0, 4'h4);
      panel_reset = (i == 0);
      serial_reset = (i == 1);
      ext_reset_req = (i > 1);
      ext_reset_enable = (i == 2);
      @(posedge sys_clk);
      #1;
      {panel_reset, serial_reset, ext_reset_req} = 3'h0;
      @(posedge sys_clk);
      #1;
      chk("latch", led_r, (i == 3) ? 4'h4 : 4'h0);
    end
    alarm_a_latch = 1'b0;
    rd(150, -101, 4'h8);
  endtask

  task automatic t_gang;
    alarm_a_gang = SPHC_GANG_BAND;
    wr(2, 50, 1'b0);
    rd(160, 0, 4'h4);
    rd(140, 0, 4'h4);
    rd(100, 0, 4'h0);
    alarm_a_direction_bit = 1'b1;
    rd(100, 0, 4'h4);
    rd(160, 0, 4'h4);
    rd(171, 0, 4'h0);
    alarm_a_gang = SPHC_GANG_ABOVE;
    alarm_a_direction_bit = 1'b0;
    rd(149, 0, 4'h0);
    rd(151, 0, 4'h4);
    alarm_a_gang = SPHC_GANG_BELOW;
    rd(29, 0, 4'h0);
    rd(51, 0, 4'h4);
    // The second alarm bands about the second control level, inside active.
    alarm_b_gang = SPHC_GANG_BAND;
    wr(3, 100, 1'b0);
    rd(51, 1000, 4'hc);
    rd(51, 1101, 4'h4);
  endtask

  // ========================================================================
  // Main sequence
  initial begin
    {meas_valid, use_filtered, level_wr_en, first_direction_bit,
      first_output_polarity, first_source_select, second_direction_bit,
      second_source_select, alarm_a_direction_bit, alarm_a_output_polarity,
      alarm_a_source_select, alarm_b_direction_bit, alarm_b_source_select,
      control_group_disable, ext_reset_enable, alarm_a_latch, alarm_b_latch,
      panel_reset, ext_reset_req, serial_reset, first_level_lock,
      second_level_lock, third_level_lock, fourth_level_lock} = '0;
    {net_raw, net_filt, gross_raw, gross_filt, level_wr_data} = '0;
    {control_hysteresis, alarm_a_hysteresis, alarm_b_hysteresis} = '0;
    {alarm_a_delay, alarm_b_delay, level_wr_sel} = '0;
    {second_output_polarity, alarm_b_output_polarity} = 2'h3;
    {alarm_group_disable, deadband_style_select, rst_n} = 3'h6;
    alarm_a_gang = SPHC_GANG_INDEP;
    alarm_b_gang = SPHC_GANG_INDEP;
    err_count = 0;
    check_count = 0;
    repeat (3) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    @(posedge sys_clk);
    #1;
    chk("led_rst", led_r, 4'h0);
    t_ctrl;
    t_dir;
    t_filt;
    t_alarm;
    t_gang;
    test_done;
  end

  // A hang would otherwise stall the run; it is scored as a mismatch.
  initial begin
    #200000;
    err_count++;
    test_done;
  end
endmodule
